// ===== src/pll_cfg_pkg.sv
// Register map, field layout and reset values of the synthesiser settings
// Overview of operation
// - Reference divides by code; codes 0,1,2 divide one
// - Prescale code: low byte plus next nibble
// - Feedback divides by code; codes 0,1 divide one
// - Prescale resets to 120, upper nibble zero
// - Divider enable routes through divider; reset bypasses
// - Synth enable turns loop on; resets off
// - Pump current code four bits, resets 0010
// - Bias bit picks supply or bandgap source
// - Resistor code five bits, resets 01111
// - Series capacitor code five bits, resets 00111
// - Shunt capacitor code five bits, resets 00111
// - Bit 7 of four registers reads zero
// - Output live only with output, bias, synth enables
// - Source bit selects synthesiser timing; resets external
package pll_cfg_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam int NREG = 11;
   localparam int IDX_SRC = 0;
   localparam int IDX_RDIV_LO = 1;
   localparam int IDX_RDIV_HI = 2;
   localparam int IDX_PRE_LO = 3;
   localparam int IDX_PRE_HI = 4;
   localparam int IDX_PUMP = 5;
   localparam int IDX_EN1 = 6;
   localparam int IDX_RES = 7;
   localparam int IDX_CAP_SER = 8;
   localparam int IDX_CAP_SHU = 9;
   localparam int IDX_EN2 = 10;

   localparam logic [7:0] REG_OFFSET [NREG] = '{
      8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
      8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5f};

   // -------------------------------------------------------------
   // Power-on values, reserved bits included
   // -------------------------------------------------------------
   localparam logic [7:0] REG_RESET [NREG] = '{
      8'h45, 8'h00, 8'h48, 8'h78, 8'h40, 8'h12,
      8'h41, 8'h2f, 8'h27, 8'h27, 8'hf1};

   // Implemented bits; bit 7 absent where unimplemented
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff};

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int SRC_SEL_BIT = 4;
   localparam int RDIV_HI_LSB = 0;
   localparam int PRE_HI_LSB = 0;
   localparam int PUMP_BIAS_BIT = 4;
   localparam int PUMP_CODE_LSB = 0;
   localparam int EN1_REFDIV_BIT = 4;
   localparam int EN1_SYNTH_BIT = 1;
   localparam int LOOP_CODE_LSB = 0;
   localparam int EN2_OUT_BIT = 3;
   localparam int EN2_BIAS_BIT = 2;

   localparam int RDIV_W = 10;
   localparam int PRE_W = 12;
   localparam int PUMP_W = 4;
   localparam int LOOP_W = 5;

endpackage

// ===== src/clk_ratio_divider.sv
// Tick divider: one output pulse per ratio input ticks
`timescale 1ns/1ps
module clk_ratio_divider #(
   parameter int WIDTH = 10
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic tick_in,
   input wire logic [WIDTH-1:0] ratio_in,
   output logic pulse_out
);

   initial begin
      if (WIDTH < 2 || WIDTH > 16) begin
         $error("clk_ratio_divider: WIDTH out of range");
      end
   end

   logic [WIDTH-1:0] count;
   wire logic [WIDTH-1:0] last_count;
   wire logic wrap;

   // Codes 0 and 1 both divide by one
   assign last_count = (ratio_in <= WIDTH'(1)) ? '0 : ratio_in - WIDTH'(1);
   // Ratio changes mid-count take effect once the counter passes it
   assign wrap = count >= last_count;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count <= '0;
         pulse_out <= 1'b0;
      end else if (!run_in) begin
         count <= '0;
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= tick_in && wrap;
         if (tick_in) begin
            count <= wrap ? '0 : count + WIDTH'(1);
         end
      end
   end

endmodule

// ===== src/pll_divider_loop_config.sv
// Synthesiser configuration registers and divider-ratio decoding
`timescale 1ns/1ps
module pll_divider_loop_config (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_hit_out,
   input wire logic ext_clk_in,
   input wire logic osc_clk_in,
   output logic [9:0] ref_divide_ratio_out,
   output logic [11:0] prescale_ratio_out,
   output logic ref_divider_on_out,
   output logic synth_on_out,
   output logic synth_out_active_out,
   output logic timing_internal_out,
   output logic bias_self_out,
   output logic [3:0] pump_current_code_out,
   output logic [4:0] loop_resistor_code_out,
   output logic [4:0] series_cap_code_out,
   output logic [4:0] shunt_cap_code_out,
   output logic ref_tick_out,
   output logic feedback_tick_out
);

   localparam int N = pll_cfg_pkg::NREG;

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   // Port widths are fixed; refuse a package whose fields outgrow them
   initial begin
      if (pll_cfg_pkg::RDIV_W != $bits(ref_divide_ratio_out) ||
            pll_cfg_pkg::PRE_W != $bits(prescale_ratio_out)) begin
         $error("pll_divider_loop_config: ratio width mismatch");
      end
      if (pll_cfg_pkg::PUMP_W != $bits(pump_current_code_out) ||
            pll_cfg_pkg::LOOP_W != $bits(loop_resistor_code_out)) begin
         $error("pll_divider_loop_config: code width mismatch");
      end
      for (int i = 0; i < N; i++) begin
         if ((pll_cfg_pkg::REG_RESET[i] & ~pll_cfg_pkg::REG_MASK[i]) !=
               8'h00) begin
            $error("pll_divider_loop_config: reset sets absent bit");
         end
      end
   end

   // -------------------------------------------------------------
   // Register storage and decode
   // -------------------------------------------------------------
   wire logic [7:0] regs [N];
   wire logic [N-1:0] hit;
   wire logic [N-1:0] wr_hit;
   wire logic [7:0] rd_term [N];
   wire logic [7:0] rd_mux;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_reg
         logic [7:0] q;
         assign hit[gi] = reg_addr_in == pll_cfg_pkg::REG_OFFSET[gi];
         assign wr_hit[gi] = reg_wr_in && hit[gi];
         assign regs[gi] = q;
         assign rd_term[gi] = hit[gi] ? q : 8'h00;
         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               q <= pll_cfg_pkg::REG_RESET[gi];
            end else if (wr_hit[gi]) begin
               // Unimplemented bits never store, so read as zero
               q <= reg_wdata_in & pll_cfg_pkg::REG_MASK[gi];
            end
         end
      end
   endgenerate

   // Reserved bits are stored as written; software keeps them
   // at power-on values by read-modify-write
   function automatic logic [7:0] or_all(input logic [7:0] t [N]);
      logic [7:0] acc;
      acc = 8'h00;
      for (int i = 0; i < N; i++) begin
         acc = acc | t[i];
      end
      return acc;
   endfunction

   assign rd_mux = or_all(rd_term);

   // Registered read data; unmapped addresses answer zero
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
         reg_hit_out <= 1'b0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_mux;
         reg_hit_out <= |hit;
      end
   end

   // -------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------
   wire logic [7:0] src_r = regs[pll_cfg_pkg::IDX_SRC];
   wire logic [7:0] pump_r = regs[pll_cfg_pkg::IDX_PUMP];
   wire logic [7:0] en1_r = regs[pll_cfg_pkg::IDX_EN1];
   wire logic [7:0] en2_r = regs[pll_cfg_pkg::IDX_EN2];
   wire logic [9:0] ref_ratio;
   wire logic [11:0] pre_ratio;

   assign ref_ratio = {regs[pll_cfg_pkg::IDX_RDIV_HI]
                       [pll_cfg_pkg::RDIV_HI_LSB +: 2],
                       regs[pll_cfg_pkg::IDX_RDIV_LO]};
   assign pre_ratio = {regs[pll_cfg_pkg::IDX_PRE_HI]
                       [pll_cfg_pkg::PRE_HI_LSB +: 4],
                       regs[pll_cfg_pkg::IDX_PRE_LO]};

   assign ref_divide_ratio_out = ref_ratio;
   assign prescale_ratio_out = pre_ratio;
   assign ref_divider_on_out = en1_r[pll_cfg_pkg::EN1_REFDIV_BIT];
   assign synth_on_out = en1_r[pll_cfg_pkg::EN1_SYNTH_BIT];
   assign timing_internal_out = src_r[pll_cfg_pkg::SRC_SEL_BIT];
   assign bias_self_out = pump_r[pll_cfg_pkg::PUMP_BIAS_BIT];
   assign pump_current_code_out =
      pump_r[pll_cfg_pkg::PUMP_CODE_LSB +: pll_cfg_pkg::PUMP_W];
   assign loop_resistor_code_out = regs[pll_cfg_pkg::IDX_RES]
      [pll_cfg_pkg::LOOP_CODE_LSB +: pll_cfg_pkg::LOOP_W];
   assign series_cap_code_out = regs[pll_cfg_pkg::IDX_CAP_SER]
      [pll_cfg_pkg::LOOP_CODE_LSB +: pll_cfg_pkg::LOOP_W];
   assign shunt_cap_code_out = regs[pll_cfg_pkg::IDX_CAP_SHU]
      [pll_cfg_pkg::LOOP_CODE_LSB +: pll_cfg_pkg::LOOP_W];

   // -------------------------------------------------------------
   // Output gating
   // -------------------------------------------------------------
   // All three enables must agree; any one alone keeps output dark
   wire logic out_enable;
   wire logic bias_enable;

   assign out_enable = en2_r[pll_cfg_pkg::EN2_OUT_BIT];
   assign bias_enable = en2_r[pll_cfg_pkg::EN2_BIAS_BIT];
   assign synth_out_active_out =
      out_enable && bias_enable && synth_on_out;

   // -------------------------------------------------------------
   // Clock pin sampling
   // -------------------------------------------------------------
   // Both clocks are far slower than ref_clk_in in this model;
   // an edge lost to sampling just lengthens one period
   logic [2:0] ext_s;
   logic [2:0] osc_s;
   wire logic ext_rise;
   wire logic osc_rise;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_s <= 3'h0;
         osc_s <= 3'h0;
      end else begin
         ext_s <= {ext_s[1:0], ext_clk_in};
         osc_s <= {osc_s[1:0], osc_clk_in};
      end
   end

   assign ext_rise = ext_s[1] && !ext_s[2];
   assign osc_rise = osc_s[1] && !osc_s[2];

   // -------------------------------------------------------------
   // Reference and feedback dividers
   // -------------------------------------------------------------
   wire logic ref_div_pulse;
   wire logic fb_div_pulse;
   logic ref_bypass_pulse;

   // Code two is refused by software; should it arrive anyway it
   // divides by one, never by two
   wire logic ref_code_two;
   wire logic [9:0] ref_ratio_eff;

   assign ref_code_two = ref_ratio == 10'h002;
   assign ref_ratio_eff = ref_code_two ? 10'h001 : ref_ratio;

   // Reference divider counts only while the loop and divider are on
   clk_ratio_divider #(
      .WIDTH(pll_cfg_pkg::RDIV_W)
   ) u_ref_div (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .run_in(synth_on_out && ref_divider_on_out),
      .tick_in(ext_rise),
      .ratio_in(ref_ratio_eff),
      .pulse_out(ref_div_pulse)
   );

   clk_ratio_divider #(
      .WIDTH(pll_cfg_pkg::PRE_W)
   ) u_fb_div (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .run_in(synth_on_out),
      .tick_in(osc_rise),
      .ratio_in(pre_ratio),
      .pulse_out(fb_div_pulse)
   );

   // Bypass path is delayed one cycle to match the divider latency
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_bypass_pulse <= 1'b0;
      end else begin
         ref_bypass_pulse <= synth_on_out && ext_rise;
      end
   end

   assign ref_tick_out = ref_divider_on_out ?
      ref_div_pulse : ref_bypass_pulse;
   assign feedback_tick_out = fb_div_pulse;

endmodule

// ===== sim/pll_cfg_properties.sv
// Port-level assertions for the synthesiser settings block
`timescale 1ns/1ps
module pll_cfg_properties (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [9:0] ref_divide_ratio_out,
   input wire logic [11:0] prescale_ratio_out,
   input wire logic ref_divider_on_out,
   input wire logic synth_on_out,
   input wire logic synth_out_active_out,
   input wire logic timing_internal_out,
   input wire logic bias_self_out,
   input wire logic [3:0] pump_current_code_out,
   input wire logic [4:0] loop_resistor_code_out,
   input wire logic [4:0] series_cap_code_out,
   input wire logic [4:0] shunt_cap_code_out,
   input wire logic ref_tick_out,
   input wire logic feedback_tick_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // Write to field, power-on, gating
   // ----------------------------------------
   sequence wr_at(a);
      reg_wr_in && reg_addr_in == a;
   endsequence
   // Ticks may still be in flight for a few cycles after disable
   sequence loop_off;
      !synth_on_out [*4];
   endsequence
   power_on_a: assert property ($fell(rst_in) |->
      {prescale_ratio_out, pump_current_code_out, loop_resistor_code_out,
      bias_self_out, synth_on_out, ref_divider_on_out} ==
      {12'h078, 4'h2, 5'h0f, 3'b100}) else $error("power-on fields wrong");
   power_rest_a: assert property ($fell(rst_in) |->
      {series_cap_code_out, shunt_cap_code_out, timing_internal_out,
      ref_divide_ratio_out} == {5'h07, 5'h07, 1'b0, 10'h000})
      else $error("power-on codes wrong");
   pre_low_a: assert property (wr_at(8'h56) |=>
      prescale_ratio_out[7:0] == $past(reg_wdata_in))
      else $error("prescale low byte");
   pre_high_a: assert property (wr_at(8'h57) |=>
      prescale_ratio_out[11:8] == 4'($past(reg_wdata_in)))
      else $error("prescale high nibble");
   enable_bits_a: assert property (wr_at(8'h59) |=>
      ref_divider_on_out == $past(reg_wdata_in[4]) &&
      synth_on_out == $past(reg_wdata_in[1])) else $error("enable bits");
   pump_code_a: assert property (wr_at(8'h58) |=>
      pump_current_code_out == 4'($past(reg_wdata_in)) &&
      bias_self_out == $past(reg_wdata_in[4])) else $error("pump fields");
   res_code_a: assert property (wr_at(8'h5a) |=>
      loop_resistor_code_out == 5'($past(reg_wdata_in)))
      else $error("resistor code");
   series_code_a: assert property (wr_at(8'h5b) |=>
      series_cap_code_out == 5'($past(reg_wdata_in)))
      else $error("series capacitor code");
   shunt_code_a: assert property (wr_at(8'h5c) |=>
      shunt_cap_code_out == 5'($past(reg_wdata_in)))
      else $error("shunt capacitor code");
   ref_low_a: assert property (wr_at(8'h54) |=>
      ref_divide_ratio_out[7:0] == $past(reg_wdata_in))
      else $error("reference ratio low byte");
   src_sel_a: assert property (wr_at(8'h53) |=>
      timing_internal_out == $past(reg_wdata_in[4]))
      else $error("source select bit");
   top_bit_a: assert property (reg_rd_in && reg_addr_in inside
      {[8'h59:8'h5c]} |=> !reg_rdata_out[7]) else $error("bit 7 set");
   fields_hold_a: assert property (!reg_wr_in |=>
      $stable(prescale_ratio_out) && $stable(synth_on_out))
      else $error("field moved without write");
   out_gate_a: assert property (
      synth_out_active_out |-> synth_on_out)
      else $error("output live while loop off");
   ticks_off_a: assert property (loop_off |-> !ref_tick_out &&
      !feedback_tick_out) else $error("tick while loop off");
   fb_pulse_a: assert property (
      feedback_tick_out |=> !feedback_tick_out)
      else $error("feedback tick too long");
endmodule
bind pll_divider_loop_config pll_cfg_properties chk_u (.ref_clk_in,
   .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
   .reg_rdata_out, .ref_divide_ratio_out, .prescale_ratio_out,
   .ref_divider_on_out, .synth_on_out, .synth_out_active_out,
   .timing_internal_out, .bias_self_out, .pump_current_code_out,
   .loop_resistor_code_out, .series_cap_code_out, .shunt_cap_code_out,
   .ref_tick_out, .feedback_tick_out);

// ===== sim/pll_divider_loop_config_tb.sv
// Self-checking bench for the synthesiser settings block
`timescale 1ns/1ps
module pll_divider_loop_config_tb;
   logic ref_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic ext_clk_in = 0, osc_clk_in = 0, rd_pend = 0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic reg_hit_out, ref_tick_out, feedback_tick_out, synth_out_active_out;
   logic [8:0] exp_q [$];
   int n_fail = 0, check_count = 0, seed = 22;
   localparam logic [7:0] FMASK [7] = '{8'hff, 8'h0f, 8'h1f, 8'h92, 8'h9f,
      8'h9f, 8'h9f};
   localparam int CODES [6] = '{120, 5, 3, 2, 1, 256};
   always #12.5 ref_clk_in = ~ref_clk_in;
   // Pin clocks: 8 and 6 cycles, edges on falling clock edges, clear of rising ones
   always #100 ext_clk_in = ~ext_clk_in;
   always #75 osc_clk_in = ~osc_clk_in;
   pll_divider_loop_config dut_u (.ref_clk_in, .rst_in, .reg_addr_in,
      .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_hit_out,
      .ext_clk_in, .osc_clk_in, .ref_divide_ratio_out(),
      .prescale_ratio_out(), .ref_divider_on_out(), .synth_on_out(),
      .synth_out_active_out, .timing_internal_out(), .bias_self_out(),
      .pump_current_code_out(), .loop_resistor_code_out(),
      .series_cap_code_out(), .shunt_cap_code_out(), .ref_tick_out,
      .feedback_tick_out);
   // ----------------------------------------
   // Drivers, monitor, compare
   // ----------------------------------------
   task automatic compare(input string what, input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1;
      @(negedge ref_clk_in);
      reg_wr_in = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1;
      exp_q.push_back(e);
      @(negedge ref_clk_in);
      reg_rd_in = 0;
   endtask
   always @(posedge ref_clk_in) rd_pend <= reg_rd_in;
   always @(negedge ref_clk_in) begin
      if (rd_pend)
         compare("read", {7'h0, reg_hit_out, reg_rdata_out},
            {7'h0, exp_q.pop_front()});
   end
   // Third tick to fourth: earlier ones may span a ratio change
   task automatic gap(input bit fb, input int exp);
      int n;
      int k;
      n = 0;
      k = 0;
      while (k < 4 && n < 20000) begin
         @(negedge ref_clk_in);
         n++;
         if ((fb ? feedback_tick_out : ref_tick_out) === 1'b1) begin
            k++;
            if (k == 3)
               n = 0;
         end
      end
      compare("gap", 16'(n), 16'(exp));
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      summarize;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      repeat (5) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      rst_in = 0;
      for (int i = 0; i < pll_cfg_pkg::NREG; i++)
         rd(pll_cfg_pkg::REG_OFFSET[i],
            {1'b1, pll_cfg_pkg::REG_RESET[i]});
      rd(8'h5d, 9'h000);
      $display("test reset done");
      // Reserved bits keep power-on values; unimplemented bit 7 reads zero
      repeat (2) begin
         for (int i = 3; i < 10; i++) begin
            d = (pll_cfg_pkg::REG_RESET[i] & ~FMASK[i-3])
               | (8'($random(seed)) & FMASK[i-3]);
            wr(pll_cfg_pkg::REG_OFFSET[i], d);
            rd(pll_cfg_pkg::REG_OFFSET[i],
               {1'b1, d & pll_cfg_pkg::REG_MASK[i]});
         end
      end
      wr(8'h53, 8'h55);
      rd(8'h53, 9'h155);
      $display("test readback done");
      // Default loop codes suit the comparison rate used here
      for (int i = 5; i < 10; i++)
         if (i != pll_cfg_pkg::IDX_EN1)
            wr(pll_cfg_pkg::REG_OFFSET[i],
               pll_cfg_pkg::REG_RESET[i]);
      wr(8'h59, 8'h41);
      wr(8'h5f, 8'hfd);
      compare("flag", {15'h0, synth_out_active_out}, 16'h0);
      wr(8'h59, 8'h53);
      compare("flag", {15'h0, synth_out_active_out}, 16'h1);
      for (int i = 0; i < 6; i++) begin
         wr(8'h56, 8'(CODES[i]));
         wr(8'h57, 8'h40 | 8'(CODES[i] >> 8));
         gap(1, (CODES[i] < 2 ? 1 : CODES[i]) * 6);
      end
      wr(8'h57, 8'h40);
      wr(8'h56, 8'h00);
      gap(1, 6);
      for (int i = 1; i < 6; i++) begin
         // Ratio code two is never programmed on the reference path
         if (CODES[i] == 2)
            continue;
         wr(8'h54, 8'(CODES[i]));
         wr(8'h55, 8'h48 | 8'(CODES[i] >> 8));
         gap(0, (CODES[i] <= 2 ? 1 : CODES[i]) * 8);
      end
      wr(8'h55, 8'h48);
      wr(8'h54, 8'h03);
      wr(8'h59, 8'h43);
      gap(0, 8);
      $display("test dividers done");
      summarize;
   end
endmodule
